// ==== rtl/tvl_framer.sv ====
// The register addresses and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`include "tvl_cfg.svh"
module tvl_framer (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic loc_valid,
  output logic loc_ready,
  input wire tvl_pkg::tvl_vec_s loc_vec,
  output logic bp_tx_valid,
  output tvl_pkg::tvl_vec_s bp_tx_vec,
  input wire logic bp_rx_valid,
  input wire tvl_pkg::tvl_vec_s bp_rx_vec,
  input wire logic bc_tick,
  input wire logic [`TVL_ID_W-1:0] bc_id,
  input wire logic [`TVL_ID_W-1:0] bc_now,
  tvl_link_if.framer_mp link,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import tvl_pkg::*;
  localparam int NS = `TVL_SLOTS;

  // Strip quality from quad count; micro quality passes through
  function automatic tvl_cand_s to_cand(tvl_vec_s v);
    tvl_cand_s c;
    c = '0;
    if (v.tech == TVL_TECH_STRIP)
      c.strip_chamber_valid = v.both_quads ? `TVL_Q_STRIP_BOTH : `TVL_Q_STRIP_ONE;
    else
      c.micro_pattern_valid = v.micro_quality;
    c.angle = v.angle;
    c.azimuth = v.azimuth;
    c.radius = v.radius;
    // A vector with no quality is dropped rather than sent as a bare slot
    if (c.strip_chamber_valid == 2'h0 && c.micro_pattern_valid == 2'h0)
      c = '0;
    return c;
  endfunction

  // Whole candidate word is the sort key: valid fields dominate, and the
  // rest breaks ties, so arrival order never changes the kept set.
  function automatic logic [NS*`TVL_CAND_W-1:0] insert(logic [NS*`TVL_CAND_W-1:0] s,
                                                        tvl_cand_s c);
    logic [NS*`TVL_CAND_W-1:0] r;
    logic [`TVL_CAND_W-1:0] cur, prev;
    r = s;
    prev = '1;
    // Top slot holds the best candidate, so slot0 leads the frame
    for (int i = NS - 1; i >= 0; i--)
    begin
      cur = s[i*`TVL_CAND_W +: `TVL_CAND_W];
      if (c > cur)
        r[i*`TVL_CAND_W +: `TVL_CAND_W] = (c <= prev) ? c : prev;
      prev = cur;
    end
    return r;
  endfunction

  logic [NS*`TVL_CAND_W-1:0] slots_q, slots_d;
  logic [`TVL_FRAME_W-1:0] tx_q;
  logic tx_valid_q, bp_tx_valid_q, enable_q;
  tvl_vec_s bp_tx_vec_q;
  logic [15:0] sent_q, drop_q, late_q;
  logic aw_got_q, w_got_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [3:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;

  wire fifo_in_ready, fifo_out_valid;
  wire [`TVL_FRAME_W-1:0] fifo_out_data;
  wire take_loc = loc_valid && fifo_in_ready && enable_q;
  // Backplane partner cannot be stalled; its vectors are merged whenever enable_q is set
  wire take_rx = bp_rx_valid && enable_q;
  wire [NS*`TVL_CAND_W-1:0] base = bc_tick ? '0 : slots_q;
  wire [NS*`TVL_CAND_W-1:0] step1 = take_loc ? insert(base, to_cand(loc_vec)) : base;
  assign slots_d = take_rx ? insert(step1, to_cand(bp_rx_vec)) : step1;
  wire [`TVL_FRAME_W-1:0] frame_new = {`TVL_HDR_WORD, slots_q,
                                       `TVL_TRL_PAD, bc_id};
  wire push_frame = bc_tick && fifo_in_ready;
  wire tx_load = !tx_valid_q || link.frame_ready;
  wire tx_fire = tx_valid_q && link.frame_ready;
  wire [`TVL_ID_W-1:0] age = bc_now - tx_q[`TVL_ID_W-1:0];
  wire late_evt = tx_fire && (age > `TVL_ID_W'(`TVL_MAX_LAT_BC));

  tvl_fifo #(.WIDTH(`TVL_FRAME_W), .DEPTH(`TVL_FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(bc_tick),
    .in_ready(fifo_in_ready),
    .in_data(frame_new),
    .out_valid(fifo_out_valid),
    .out_ready(tx_load),
    .out_data(fifo_out_data)
  );

  // Register bus decode
  wire aw_fire = s_axi_awvalid && awready_q;
  wire w_fire = s_axi_wvalid && wready_q;
  wire aw_have = aw_got_q || aw_fire;
  wire w_have = w_got_q || w_fire;
  wire [3:0] wa = aw_got_q ? awaddr_q : s_axi_awaddr;
  wire [31:0] wd = w_got_q ? wdata_q : s_axi_wdata;
  wire [3:0] ws = w_got_q ? wstrb_q : s_axi_wstrb;
  wire wr_do = aw_have && w_have && !bvalid_q;
  wire wr_ctrl = wr_do && wa == `TVL_REG_CTRL && ws[0];
  wire cnt_clr = wr_ctrl && wd[1];
  wire ar_fire = s_axi_arvalid && arready_q;
  wire rd_hit = s_axi_araddr == `TVL_REG_CTRL || s_axi_araddr == `TVL_REG_STAT ||
                s_axi_araddr == `TVL_REG_DROP || s_axi_araddr == `TVL_REG_LATE;
  wire [31:0] rd_mux = (s_axi_araddr == `TVL_REG_CTRL) ? {31'h0, enable_q} :
                       (s_axi_araddr == `TVL_REG_STAT) ? {15'h0, tx_valid_q, sent_q} :
                       (s_axi_araddr == `TVL_REG_DROP) ? {16'h0, drop_q} :
                       (s_axi_araddr == `TVL_REG_LATE) ? {16'h0, late_q} : 32'h0;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      slots_q <= '0;
      tx_q <= '0;
      tx_valid_q <= 1'b0;
      bp_tx_valid_q <= 1'b0;
      bp_tx_vec_q <= '0;
      enable_q <= `TVL_CTRL_RST;
    end
    else
    begin
      slots_q <= slots_d;
      if (tx_load)
      begin
        tx_valid_q <= fifo_out_valid;
        tx_q <= fifo_out_data;
      end
      bp_tx_valid_q <= take_loc;
      bp_tx_vec_q <= loc_vec;
      if (wr_ctrl)
        enable_q <= wd[0];
    end
  end

  // Counters: an event in the clearing cycle still counts
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sent_q <= '0;
      drop_q <= '0;
      late_q <= '0;
    end
    else
    begin
      sent_q <= (cnt_clr ? 16'h0 : sent_q) + 16'(tx_fire);
      drop_q <= (cnt_clr ? 16'h0 : drop_q) + 16'(bc_tick && !push_frame);
      late_q <= (cnt_clr ? 16'h0 : late_q) + 16'(late_evt);
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `TVL_RESP_OK;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= `TVL_RESP_OK;
    end
    else
    begin
      aw_got_q <= aw_have && !wr_do;
      w_got_q <= w_have && !wr_do;
      awready_q <= !(aw_have && !wr_do);
      wready_q <= !(w_have && !wr_do);
      if (aw_fire)
        awaddr_q <= s_axi_awaddr;
      if (w_fire)
      begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_do)
        bresp_q <= (wa == `TVL_REG_CTRL) ? `TVL_RESP_OK : `TVL_RESP_ERR;
      bvalid_q <= wr_do || (bvalid_q && !s_axi_bready);
      rvalid_q <= ar_fire || (rvalid_q && !s_axi_rready);
      arready_q <= !(ar_fire || (rvalid_q && !s_axi_rready));
      if (ar_fire)
      begin
        rdata_q <= rd_mux;
        rresp_q <= rd_hit ? `TVL_RESP_OK : `TVL_RESP_ERR;
      end
    end
  end

  assign loc_ready = fifo_in_ready;
  assign link.frame = tx_q;
  assign link.frame_valid = tx_valid_q;
  assign bp_tx_valid = bp_tx_valid_q;
  assign bp_tx_vec = bp_tx_vec_q;
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
endmodule

// ==== rtl/tvl_cfg.svh ====
`ifndef TVL_CFG_SVH
`define TVL_CFG_SVH
// Link and frame format
`define TVL_LINE_MBPS 6400
`define TVL_FRAME_W 128
`define TVL_CAND_W 24
`define TVL_SLOTS 4
`define TVL_ID_W 12
`define TVL_HDR_WORD 16'hA5C3
`define TVL_HDR_LSB 112
`define TVL_SLOT0_LSB 88
`define TVL_TRL_PAD 4'h0
// Strip-chamber quality codes
`define TVL_Q_STRIP_BOTH 2'h3
`define TVL_Q_STRIP_ONE 2'h1
// Latency budget in crossings; crossing period in ns
`define TVL_BC_NS 25
`define TVL_MAX_LAT_NS 1025
`define TVL_MAX_LAT_BC (`TVL_MAX_LAT_NS / `TVL_BC_NS)
`define TVL_FIFO_DEPTH 8
// Register map, byte addresses
`define TVL_REG_CTRL 4'h0
`define TVL_REG_STAT 4'h4
`define TVL_REG_DROP 4'h8
`define TVL_REG_LATE 4'hC
`define TVL_CTRL_RST 1'h1
`define TVL_RESP_OK 2'h0
`define TVL_RESP_ERR 2'h2
// Receiver matching windows and momentum steps
`define TVL_AZ_WIN 6'h2
`define TVL_R_WIN 8'h4
`define TVL_ANG_WIN 5'h3
`define TVL_PT_SETS 10
`define TVL_PT_STEP 3
`endif

// ==== rtl/tvl_pkg.sv ====
package tvl_pkg;
  typedef struct packed {
    logic [1:0] strip_chamber_valid;
    logic [1:0] micro_pattern_valid;
    logic [4:0] angle;
    logic [5:0] azimuth;
    logic [7:0] radius;
    logic spare;
  } tvl_cand_s;

  typedef enum logic {TVL_TECH_STRIP, TVL_TECH_MICRO} tvl_tech_e;

  typedef struct packed {
    tvl_tech_e tech;
    logic both_quads;
    logic [1:0] micro_quality;
    logic [4:0] angle;
    logic [5:0] azimuth;
    logic [7:0] radius;
  } tvl_vec_s;

  typedef struct packed {
    logic [3:0] pt_code;
    logic [5:0] azimuth;
    logic [7:0] radius;
    logic [1:0] quality;
  } tvl_trk_s;
endpackage

// ==== rtl/tvl_link_if.sv ====
`timescale 1ns/1ps
`include "tvl_cfg.svh"
interface tvl_link_if (
  input wire logic clk,
  input wire logic sys_rst
);
  logic [`TVL_FRAME_W-1:0] frame;
  logic frame_valid;
  logic frame_ready;
  modport framer_mp (output frame, output frame_valid, input frame_ready);
  modport receiver_mp (input frame, input frame_valid, output frame_ready);
endinterface

// ==== rtl/tvl_receiver.sv ====
`timescale 1ns/1ps
`include "tvl_cfg.svh"
module tvl_fifo #(
  parameter int WIDTH = `TVL_FRAME_W,
  parameter int DEPTH = `TVL_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  // Depth must be a power of two for the wrap bit scheme
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q, rd_q;
  wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire empty = (wr_q == rd_q);
  wire push = in_valid && !full;
  wire pop = out_ready && !empty;
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge clk)
  begin
    if (push)
      mem_q[wr_q[AW-1:0]] <= in_data;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      wr_q <= wr_q + (AW+1)'(push);
      rd_q <= rd_q + (AW+1)'(pop);
    end
  end
endmodule

module tvl_receiver (
  input wire logic clk,
  input wire logic sys_rst,
  tvl_link_if.receiver_mp link,
  input wire logic accept_en,
  input wire logic [5:0] roi_azimuth,
  input wire logic [7:0] roi_radius,
  input wire logic [4:0] roi_angle,
  input wire logic l1_accept,
  output logic trk_valid,
  output logic [1:0] trk_present,
  output tvl_pkg::tvl_trk_s trk0,
  output tvl_pkg::tvl_trk_s trk1,
  output logic [`TVL_ID_W-1:0] trk_id,
  output logic hdr_err,
  output logic readout_valid,
  output logic [`TVL_FRAME_W-1:0] readout_in,
  output logic [2*$bits(tvl_pkg::tvl_trk_s)-1:0] readout_out
);
  import tvl_pkg::*;
  localparam int NS = `TVL_SLOTS;

  // Count of momentum thresholds passed; smaller angle means harder track
  function automatic logic [3:0] pt_of(logic [4:0] ang);
    logic [3:0] n;
    n = '0;
    for (int i = 0; i < `TVL_PT_SETS; i++)
      if (int'(ang) <= `TVL_PT_STEP * (`TVL_PT_SETS - i))
        n = n + 4'h1;
    return n;
  endfunction

  function automatic logic [7:0] absdiff(logic [7:0] a, logic [7:0] b);
    return (a > b) ? a - b : b - a;
  endfunction

  logic [`TVL_FRAME_W-1:0] f1_q;
  logic v1_q, v2_q, ready_q;
  tvl_trk_s cand_q [NS];
  logic [NS-1:0] match_q;
  logic [`TVL_ID_W-1:0] id2_q;
  logic trk_valid_q, hdr_err_q, ro_valid_q;
  logic [1:0] present_q;
  tvl_trk_s trk0_q, trk1_q;
  logic [`TVL_ID_W-1:0] id_q;
  logic [`TVL_FRAME_W-1:0] ro_in_q;
  logic [2*$bits(tvl_trk_s)-1:0] ro_out_q;

  wire take = link.frame_valid && ready_q;
  wire hdr_ok = f1_q[`TVL_FRAME_W-1 -: 16] == `TVL_HDR_WORD;

  tvl_trk_s dec [NS];
  logic [NS-1:0] mt;
  genvar g;
  generate
    for (g = 0; g < NS; g++)
    begin : g_slot
      tvl_cand_s c;
      wire any_v = (c.strip_chamber_valid != 2'h0) || (c.micro_pattern_valid != 2'h0);
      assign c = f1_q[`TVL_SLOT0_LSB - g*`TVL_CAND_W +: `TVL_CAND_W];
      assign mt[g] = any_v && hdr_ok &&
                     absdiff({2'h0, c.azimuth}, {2'h0, roi_azimuth}) <= {2'h0, `TVL_AZ_WIN} &&
                     absdiff(c.radius, roi_radius) <= `TVL_R_WIN &&
                     absdiff({3'h0, c.angle}, {3'h0, roi_angle}) <=
                       {3'h0, `TVL_ANG_WIN};
      assign dec[g] = '{pt_code: pt_of(c.angle), azimuth: c.azimuth, radius: c.radius,
                        quality: {(c.strip_chamber_valid != 2'h0) &&
                                  (c.micro_pattern_valid != 2'h0), 1'b1}};
    end
  endgenerate

  // Best and second best matched tracks by momentum, lowest slot on ties
  function automatic int pick(tvl_trk_s t [NS], logic [NS-1:0] m, int skip);
    int b;
    b = -1;
    for (int i = 0; i < NS; i++)
      if (m[i] && i != skip && (b < 0 || t[i].pt_code > t[b].pt_code))
        b = i;
    return b;
  endfunction

  int best0, best1;
  always_comb
  begin
    best0 = pick(cand_q, match_q, -1);
    best1 = pick(cand_q, match_q, best0);
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ready_q <= 1'b0;
      v1_q <= 1'b0;
      f1_q <= '0;
      v2_q <= 1'b0;
      match_q <= '0;
      id2_q <= '0;
      for (int i = 0; i < NS; i++)
        cand_q[i] <= '0;
      hdr_err_q <= 1'b0;
    end
    else
    begin
      ready_q <= accept_en;
      v1_q <= take;
      if (take)
        f1_q <= link.frame;
      v2_q <= v1_q;
      match_q <= v1_q ? mt : '0;
      id2_q <= f1_q[`TVL_ID_W-1:0];
      for (int i = 0; i < NS; i++)
        cand_q[i] <= dec[i];
      hdr_err_q <= v1_q && !hdr_ok;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      trk_valid_q <= 1'b0;
      present_q <= '0;
      trk0_q <= '0;
      trk1_q <= '0;
      id_q <= '0;
      ro_valid_q <= 1'b0;
      ro_in_q <= '0;
      ro_out_q <= '0;
    end
    else
    begin
      trk_valid_q <= v2_q;
      if (v2_q)
      begin
        present_q <= {best1 >= 0, best0 >= 0};
        trk0_q <= (best0 >= 0) ? cand_q[best0[1:0]] : '0;
        trk1_q <= (best1 >= 0) ? cand_q[best1[1:0]] : '0;
        id_q <= id2_q;
      end
      ro_valid_q <= l1_accept;
      if (l1_accept)
      begin
        ro_in_q <= f1_q;
        ro_out_q <= {trk1_q, trk0_q};
      end
    end
  end

  assign link.frame_ready = ready_q;
  assign trk_valid = trk_valid_q;
  assign trk_present = present_q;
  assign trk0 = trk0_q;
  assign trk1 = trk1_q;
  assign trk_id = id_q;
  assign hdr_err = hdr_err_q;
  assign readout_valid = ro_valid_q;
  assign readout_in = ro_in_q;
  assign readout_out = ro_out_q;
endmodule

// ==== test/tvl_link_monitor.sv ====
`timescale 1ns/1ps
`include "tvl_cfg.svh"
module tvl_link_monitor (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [`TVL_FRAME_W-1:0] frame,
  input wire logic frame_valid,
  input wire logic frame_ready
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire [23:0] s0 = frame[111:88];
  wire [23:0] s1 = frame[87:64];
  wire [23:0] s2 = frame[63:40];
  wire [23:0] s3 = frame[39:16];
  // Empty means all four valid bits clear, so the rest must be clear too
  chk_hdr_word: assert property (frame_valid |-> frame[127:112] == `TVL_HDR_WORD)
    else $error("header word wrong");
  chk_trl_pad: assert property (frame_valid |-> frame[15:12] == `TVL_TRL_PAD)
    else $error("trailer pad wrong");
  chk_frame_hold: assert property (frame_valid && !frame_ready |=>
    frame_valid && $stable(frame))
    else $error("frame changed before taken");
  chk_spare_zero: assert property (frame_valid |->
    !(frame[88] | frame[64] | frame[40] | frame[16]))
    else $error("spare bit set");
  chk_empty_slot: assert property (frame_valid |->
    (|s0[23:20] || s0 == 0) && (|s1[23:20] || s1 == 0)
    && (|s2[23:20] || s2 == 0) && (|s3[23:20] || s3 == 0))
    else $error("empty slot not zero");
  chk_best_first: assert property (frame_valid |-> s0 >= s1 && s0 >= s2 && s0 >= s3)
    else $error("slot0 not best");
  chk_strip_code: assert property (frame_valid |-> s0[23:22] != 2'h2
    && s1[23:22] != 2'h2 && s2[23:22] != 2'h2 && s3[23:22] != 2'h2)
    else $error("bad strip code");
  chk_rst_idle: assert property ($fell(sys_rst) |-> !frame_valid)
    else $error("frame valid out of reset");
endmodule

// ==== test/trigger_vector_link_framer_tb.sv ====
`timescale 1ns/1ps
`include "tvl_cfg.svh"
module trigger_vector_link_framer_tb;
  import tvl_pkg::*;
  logic clk, sys_rst, loc_valid, bp_rx_valid, bc_tick, accept_en, l1_accept;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic [3:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [11:0] bc_id, bc_now;
  tvl_vec_s loc_vec, bp_rx_vec, bp_tx_vec;
  tvl_trk_s trk0, trk1, l_t0, l_t1;
  wire logic loc_ready, bp_tx_valid, awready, wready, bvalid, arready, rvalid;
  wire logic trk_valid, hdr_err, ro_valid;
  wire logic [1:0] bresp, rresp, trk_present;
  wire logic [31:0] rdata;
  wire logic [11:0] trk_id;
  wire logic [127:0] ro_in;
  wire logic [39:0] ro_out;
  logic [1:0] l_pres;
  logic [11:0] l_id;
  logic [127:0] last_frame;
  int err_count, checks, sent_n, trk_n, hdr_n;
  time take_t, trk_t;
  tvl_link_if tvl_link_if_inst (.clk(clk), .sys_rst(sys_rst));
  tvl_framer tvl_framer_inst (.clk(clk), .sys_rst(sys_rst), .loc_valid(loc_valid),
    .loc_ready(loc_ready), .loc_vec(loc_vec), .bp_tx_valid(bp_tx_valid), .bp_tx_vec(bp_tx_vec),
    .bp_rx_valid(bp_rx_valid), .bp_rx_vec(bp_rx_vec), .bc_tick(bc_tick), .bc_id(bc_id),
    .bc_now(bc_now), .link(tvl_link_if_inst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  tvl_receiver tvl_receiver_inst (.clk(clk), .sys_rst(sys_rst), .link(tvl_link_if_inst),
    .accept_en(accept_en), .roi_azimuth(6'hA), .roi_radius(8'h64), .roi_angle(5'h5),
    .l1_accept(l1_accept), .trk_valid(trk_valid), .trk_present(trk_present), .trk0(trk0),
    .trk1(trk1), .trk_id(trk_id), .hdr_err(hdr_err), .readout_valid(ro_valid),
    .readout_in(ro_in), .readout_out(ro_out));
  tvl_link_monitor tvl_link_monitor_inst (.clk(clk), .sys_rst(sys_rst),
    .frame(tvl_link_if_inst.frame), .frame_valid(tvl_link_if_inst.frame_valid),
    .frame_ready(tvl_link_if_inst.frame_ready));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Outputs that stand one cycle are captured at the edge that sees them
  always @(posedge clk)
  begin
    if (!sys_rst && tvl_link_if_inst.frame_valid && tvl_link_if_inst.frame_ready)
    begin
      last_frame = tvl_link_if_inst.frame;
      sent_n++;
      take_t = $time;
    end
    if (trk_valid)
    begin
      trk_n++;
      trk_t = $time;
      {l_t1, l_t0, l_pres, l_id} = {trk1, trk0, trk_present, trk_id};
    end
    if (hdr_err)
      hdr_n++;
  end

  task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
    checks++;
    if (e !== g)
    begin
      $display("mismatch %s exp %0h got %0h", nm, e, g);
      err_count++;
    end
  endtask

  function automatic logic [127:0] fr(logic [11:0] id, logic [95:0] slots);
    return {`TVL_HDR_WORD, slots, `TVL_TRL_PAD, id};
  endfunction

  function automatic logic [23:0] cw(tvl_vec_s v);
    return {v.tech == TVL_TECH_STRIP ? (v.both_quads ? `TVL_Q_STRIP_BOTH : `TVL_Q_STRIP_ONE)
      : 2'h0, v.tech == TVL_TECH_MICRO ? v.micro_quality : 2'h0, v.angle, v.azimuth, v.radius,
      1'b0};
  endfunction

  task automatic tick(input logic [11:0] id, input logic [11:0] lag);
    @(posedge clk);
    bc_tick <= 1'b1;
    bc_id <= id;
    bc_now <= id + lag;
    @(posedge clk);
    bc_tick <= 1'b0;
  endtask

  task automatic wait_frames(input int n);
    repeat (300) if (sent_n < n) @(posedge clk);
    chk("frames sent", n, sent_n);
  endtask

  task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk("bresp", er, bresp);
  endtask

  task automatic regchk(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk("register read", {e, er}, {rdata, rresp});
  endtask

  task automatic send_loc(input tvl_vec_s v);
    @(posedge clk);
    loc_valid <= 1'b1;
    loc_vec <= v;
    do @(posedge clk); while (!loc_ready);
    loc_valid <= 1'b0;
    @(posedge clk);
    chk("backplane tx", {1'b1, v}, {bp_tx_valid, bp_tx_vec});
  endtask

  task automatic send_rem(input tvl_vec_s v);
    @(posedge clk);
    bp_rx_valid <= 1'b1;
    bp_rx_vec <= v;
    @(posedge clk);
    bp_rx_valid <= 1'b0;
  endtask

  task automatic t_regs;
    regchk(`TVL_REG_CTRL, 32'h1, `TVL_RESP_OK);
    regchk(`TVL_REG_STAT, 32'h0, `TVL_RESP_OK);
    regchk(`TVL_REG_DROP, 32'h0, `TVL_RESP_OK);
    regchk(`TVL_REG_LATE, 32'h0, `TVL_RESP_OK);
    regchk(4'h2, 32'h0, `TVL_RESP_ERR);
    axw(`TVL_REG_STAT, 32'h1, `TVL_RESP_ERR);
  endtask

  task automatic t_empty;
    tick(12'h123, 12'h0);
    wait_frames(1);
    chk("empty frame", fr(12'h123, 96'h0), last_frame);
    repeat (20) if (trk_n < 1) @(posedge clk);
    chk("empty tracks", {2'h0, 12'h123}, {l_pres, l_id});
    chk("track latency", 3 * 40, trk_t - take_t);
  endtask

  task automatic t_merge;
    tvl_vec_s a, b, c, d, e;
    logic [127:0] x;
    a = {TVL_TECH_STRIP, 1'b1, 2'h0, 5'h5, 6'hA, 8'h64};
    b = {TVL_TECH_STRIP, 1'b0, 2'h0, 5'h5, 6'hA, 8'h64};
    c = {TVL_TECH_MICRO, 1'b0, 2'h2, 5'h14, 6'h28, 8'hC8};
    d = {TVL_TECH_MICRO, 1'b0, 2'h3, 5'h14, 6'h32, 8'hC8};
    e = {TVL_TECH_MICRO, 1'b0, 2'h1, 5'h1, 6'h3C, 8'h10};
    x = fr(12'h0A1, {cw(a), cw(b), cw(d), cw(c)});
    send_loc(b);
    send_rem(e);
    send_loc(a);
    send_rem(c);
    send_rem(d);
    tick(12'h0A1, 12'h0);
    wait_frames(2);
    chk("merged frame", x, last_frame);
    repeat (20) if (trk_n < 2) @(posedge clk);
    chk("tracks", {2{4'h9, 6'hA, 8'h64, 2'h1}}, {l_t1, l_t0});
    chk("track flags", {2'h3, 12'h0A1}, {l_pres, l_id});
    @(posedge clk);
    l1_accept <= 1'b1;
    @(posedge clk);
    l1_accept <= 1'b0;
    @(posedge clk);
    chk("readout", {1'b1, x}, {ro_valid, ro_in});
    chk("readout out", {2{4'h9, 6'hA, 8'h64, 2'h1}}, ro_out);
  endtask

  task automatic t_full;
    accept_en <= 1'b0;
    for (int i = 0; i < 10; i++)
    begin
      tick(12'h200 + 12'(i), 12'h0);
      @(posedge clk);
    end
    chk("local ready when full", 1'b0, loc_ready);
    regchk(`TVL_REG_DROP, 32'h1, `TVL_RESP_OK);
    accept_en <= 1'b1;
    wait_frames(11);
    chk("last kept id", 12'h208, last_frame[11:0]);
    repeat (10) @(posedge clk);
    chk("no extra frame", 11, sent_n);
    regchk(`TVL_REG_STAT, 32'hB, `TVL_RESP_OK);
  endtask

  task automatic t_late;
    tick(12'hFF0, 12'h2A);
    tick(12'h010, 12'h29);
    wait_frames(13);
    regchk(`TVL_REG_LATE, 32'h1, `TVL_RESP_OK);
    axw(`TVL_REG_CTRL, 32'h3, `TVL_RESP_OK);
    regchk(`TVL_REG_LATE, 32'h0, `TVL_RESP_OK);
    regchk(`TVL_REG_DROP, 32'h0, `TVL_RESP_OK);
    axw(`TVL_REG_CTRL, 32'h0, `TVL_RESP_OK);
    regchk(`TVL_REG_CTRL, 32'h0, `TVL_RESP_OK);
    send_rem({TVL_TECH_STRIP, 1'b1, 2'h0, 5'h5, 6'hA, 8'h64});
    tick(12'h030, 12'h0);
    wait_frames(14);
    chk("disabled frame", fr(12'h030, 96'h0), last_frame);
    chk("header errors", 0, hdr_n);
  endtask

  task automatic end_sim;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    end_sim();
  end

  initial
  begin
    {sys_rst, accept_en} = 2'h3;
    {loc_valid, bp_rx_valid, bc_tick, l1_accept} = 4'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata, bc_id, bc_now} = 64'h0;
    {loc_vec, bp_rx_vec} = '0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_regs();
    t_empty();
    t_merge();
    t_full();
    t_late();
    end_sim();
  end
endmodule
